// *** core/adc_conversion_sequencer.sv ***
// Purpose: converter end: conversion sequencing, ready flag and result coding
// Assumes: all logic runs on link_clk; sample_value_i and rate_sel_i come
//          from filter logic on the same clock
//          rst_b_i may come from another clock
// Notes:   the analog filter is outside; this block times and codes results
//          figures are in link cycles: LINK_CLOCK_HZ must match the host
//
// Behaviour
// - ready held high after selection change
// - first result after change is settled
// - host writes selection, then reads data
// - selection: positive high digit, negative low
// - resume in low power starts conversion
// - one-shot ready falls after settle interval
// - host sends low power after reading
// - keep converting after restart, change, wake
// - ready period equals reciprocal data rate
// - settle periods 5, 3, 2, else 1
// - host should restart after input step
// - without restart host discards next result
// - result is 24-bit two's complement
// - full scale codes 7fffff and 800000
// - beyond full scale saturates, never wraps
// - restart pin low: ready high, then falls
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_conversion_sequencer #(
   parameter int LINK_CLOCK_HZ = `LINK_CLOCK_HZ
) (
   adc_link_if.device           link,
   input  wire logic            rst_b_i,
   input  wire logic signed [31:0] sample_value_i,
   input  wire logic [1:0]      rate_sel_i,
   output logic [3:0]           positive_input_o,
   output logic [3:0]           negative_input_o,
   output logic                 standby_o
);

   // reset as seen on link_clk
   logic                        rst_meta;
   logic                        link_rst_b;

   // sequencing state and period counter
   adc_seq_pkg::dev_state_type  state;
   logic [15:0]                 count;

   // selection and the last coded result
   logic [7:0]                  input_select_reg;
   logic                        ready_n;
   logic [23:0]                 result;

   // command decodes, one link edge each
   logic                        take_cmd;
   logic                        change_select;
   logic                        wake;

   // result period in link cycles for a rate code
   // integer division rounds the period down
   function automatic logic [15:0] period_cycles(input logic [1:0] rate);
      int sps;

      sps = `RATE_3750_SPS;
      unique case (rate)
         2'h0: sps = `RATE_30K_SPS;
         2'h1: sps = `RATE_15K_SPS;
         2'h2: sps = `RATE_7500_SPS;
         2'h3: sps = `RATE_3750_SPS;
      endcase
      return 16'(LINK_CLOCK_HZ / sps);
   endfunction : period_cycles

   // settle interval in link cycles, whole periods for the rate
   // 16 bits suffice for all four rates at the default LINK_CLOCK_HZ
   function automatic logic [15:0] settle_cycles(input logic [1:0] rate);
      logic [15:0] periods;

      periods = `SETTLE_SLOW_PERIODS;
      unique case (rate)
         2'h0: periods = `SETTLE_30K_PERIODS;
         2'h1: periods = `SETTLE_15K_PERIODS;
         2'h2: periods = `SETTLE_7500_PERIODS;
         2'h3: periods = `SETTLE_SLOW_PERIODS;
      endcase
      return 16'(periods * period_cycles(rate));
   endfunction : settle_cycles

   // clip a wide filter word into the 24-bit result code
   // compared in 32 bits so no wide word aliases into range
   function automatic logic [23:0] saturate(input logic signed [31:0] value);
      logic signed [31:0] pos_limit;
      logic signed [31:0] neg_limit;
      pos_limit = {8'h00, `RESULT_POS_FULL};
      neg_limit = {8'hff, `RESULT_NEG_FULL};

      if (value > pos_limit) begin
         return `RESULT_POS_FULL;
      end else if (value < neg_limit) begin
         return `RESULT_NEG_FULL;
      end
      return value[23:0];
   endfunction : saturate

   // reset arrives from the host clock; two flops bring it onto link_clk
   // hold reset for at least four link periods
   always_ff @(posedge link.link_clk) begin
      rst_meta   <= rst_b_i;
      link_rst_b <= rst_meta;
   end

   // a command is taken at any link edge with valid high
   assign take_cmd      = link.cmd_valid;
   assign change_select = take_cmd && (link.cmd_code == adc_seq_pkg::register_write_cmd);
   assign wake          = take_cmd && (link.cmd_code == adc_seq_pkg::wakeup_cmd);

   // selection register; a write outside low power also restarts the filter below
   always_ff @(posedge link.link_clk) begin
      if (!link_rst_b) begin
         input_select_reg <= `SELECT_RESET;
      end else if (change_select) begin
         input_select_reg <= link.cmd_data;
      end
   end

   // any digit pair is passed on unchecked
   // split selection digits
   assign positive_input_o = input_select_reg[`SELECT_POS_MSB:`SELECT_POS_LSB];
   assign negative_input_o = input_select_reg[`SELECT_NEG_MSB:`SELECT_NEG_LSB];

   // sequencing: restart pin first, then leaving restart, then commands, then the period counter
   // a write in low power stores the selection but starts nothing;
   // the host must wake the converter to measure the new inputs
   always_ff @(posedge link.link_clk) begin
      if (!link_rst_b) begin
         state   <= adc_seq_pkg::dev_restart;
         count   <= 16'h0000;
         ready_n <= 1'b1;
         result  <= 24'h000000;
      end else if (link.restart_powerdown_pin) begin
         // the pin also drops a conversion in flight
         // filter held while pin high
         state   <= adc_seq_pkg::dev_restart;
         ready_n <= 1'b1;
      end else if (state == adc_seq_pkg::dev_restart) begin
         // rate is sampled at every start and every result
         // pin low starts settling
         state   <= adc_seq_pkg::dev_settling;
         count   <= settle_cycles(rate_sel_i) - 16'h0001;
         ready_n <= 1'b1;
      end else if (take_cmd && link.cmd_code == adc_seq_pkg::standby_cmd) begin
         // low power: counter frozen, ready held high
         state   <= adc_seq_pkg::dev_standby;
         ready_n <= 1'b1;
      end else if (change_select && state != adc_seq_pkg::dev_standby) begin
         state   <= adc_seq_pkg::dev_settling;
         count   <= settle_cycles(rate_sel_i) - 16'h0001;
         ready_n <= 1'b1;
      end else if (wake && state == adc_seq_pkg::dev_standby) begin
         // a wake outside low power is ignored
         // wake starts settling, then continuous conversion
         state   <= adc_seq_pkg::dev_settling;
         count   <= settle_cycles(rate_sel_i) - 16'h0001;
         ready_n <= 1'b1;
      end else begin
         if (take_cmd && link.cmd_code == adc_seq_pkg::read_data_cmd) begin
            ready_n <= 1'b1;
         end
         // a completion in the same edge as a read wins
         unique case (state)
            adc_seq_pkg::dev_settling, adc_seq_pkg::dev_converting: begin
               // zero once per settle interval or period
               if (count == 16'h0000) begin
                  result  <= saturate(sample_value_i);
                  ready_n <= 1'b0;
                  state   <= adc_seq_pkg::dev_converting;
                  count   <= period_cycles(rate_sel_i) - 16'h0001;
               end else begin
                  count <= count - 16'h0001;
                  // raise ready one cycle early so every result shows a fall
                  if (count == 16'h0001 && state == adc_seq_pkg::dev_converting) begin
                     ready_n <= 1'b1;
                  end
               end
            end
            adc_seq_pkg::dev_standby, adc_seq_pkg::dev_restart: begin
               // standby held until a wake or the pin; restart is left in the branch above
            end
         endcase
      end
   end

   // ready and result straight from flops
   assign link.result_ready_n = ready_n;
   assign link.result_data    = result;
   assign standby_o           = (state == adc_seq_pkg::dev_standby);

endmodule : adc_conversion_sequencer

// *** core/adc_host_controller.sv ***
// Purpose: host end: makes the link clock, cycles inputs, runs one-shots
// Assumes: clock_i at 20 MHz; ready flag arrives from the link domain
// Notes:   results queue in a small fifo; a full fifo stalls the reads
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module result_fifo #(
   parameter int WIDTH = `RESULT_WIDTH,
   parameter int DEPTH = `FIFO_DEPTH
) (
   input  wire logic             clock_i,
   input  wire logic             rst_b_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      fill;
   logic             push;
   logic             pop;

   assign in_ready_o  = (fill != (AW+1)'(DEPTH));
   assign out_valid_o = (fill != '0);
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;
   assign out_data_o  = mem[rd_ptr];

   // storage needs no reset; fill guards every read
   always_ff @(posedge clock_i) begin
      if (push) begin
         mem[wr_ptr] <= in_data_i;
      end
   end

   // pointers wrap naturally; depth is assumed a power of two
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         fill   <= '0;
      end else begin
         if (push) wr_ptr <= AW'(wr_ptr + 1'b1);
         if (pop) rd_ptr <= AW'(rd_ptr + 1'b1);
         if (push && !pop) fill <= (AW+1)'(fill + 1'b1);
         else if (pop && !push) fill <= (AW+1)'(fill - 1'b1);
      end
   end
endmodule : result_fifo

module adc_host_controller (
   adc_link_if.host     link,
   input  wire logic    clock_i,
   input  wire logic    rst_b_i,
   input  wire logic    run_i,
   input  wire logic [7:0] next_select_i,
   input  wire logic    oneshot_i,
   input  wire logic    restart_i,
   output logic         result_valid_o,
   output logic [23:0]  result_data_o,
   input  wire logic    result_ready_i,
   output logic         busy_o
);

   logic [1:0]                  div_cnt;
   logic                        tick;
   logic                        ready_meta;
   logic                        ready_sync;
   logic                        ready_prev;
   logic                        ready_fall;
   logic                        data_pending;
   logic                        restart_pend;
   logic                        oneshot_pend;
   logic                        oneshot_active;
   logic                        fifo_in_ready;
   logic                        push;
   logic                        cmd_valid;
   adc_seq_pkg::cmd_code_type   cmd_code;
   logic [7:0]                  cmd_data;
   logic                        restart_pin;
   adc_seq_pkg::host_state_type state;

   // divide by four; outputs change as link_clk falls, two cycles before rising
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) div_cnt <= 2'h0;
      else div_cnt <= div_cnt + 2'h1;
   end
   assign link.link_clk = div_cnt[1];
   assign tick          = (div_cnt == `LINK_DIV_LAST);

   // ready flag crosses from the link domain through two flops
   always_ff @(posedge clock_i) begin
      ready_meta <= link.result_ready_n;
      ready_sync <= ready_meta;
      ready_prev <= ready_sync;
   end
   assign ready_fall = ready_prev && !ready_sync;

   // one read per tick; the full fifo holds it off, so the result waits
   assign push = tick && fifo_in_ready && data_pending
                 && ((state == adc_seq_pkg::h_read)
                 || (state == adc_seq_pkg::h_wait && oneshot_active));

   // request flags: a new event wins over its clear
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         data_pending <= 1'b0;
         restart_pend <= 1'b0;
         oneshot_pend <= 1'b0;
      end else begin
         // a result only after ready falls
         if (ready_fall) data_pending <= 1'b1;
         else if (push) data_pending <= 1'b0;
         if (restart_i) restart_pend <= 1'b1;
         else if (tick && state == adc_seq_pkg::h_idle) restart_pend <= 1'b0;
         if (oneshot_i) oneshot_pend <= 1'b1;
         else if (tick && state == adc_seq_pkg::h_idle && !restart_pend) oneshot_pend <= 1'b0;
      end
   end

   // command sequencing, advanced once per link period
   always_ff @(posedge clock_i) begin
      if (!rst_b_i) begin
         state          <= adc_seq_pkg::h_idle;
         cmd_valid      <= 1'b0;
         cmd_code       <= adc_seq_pkg::read_data_cmd;
         cmd_data       <= 8'h00;
         restart_pin    <= 1'b0;
         oneshot_active <= 1'b0;
      end else if (tick) begin
         cmd_valid   <= 1'b0;
         restart_pin <= 1'b0;
         unique case (state)
            adc_seq_pkg::h_idle: begin
               if (restart_pend) begin
                  restart_pin <= 1'b1;
                  state       <= adc_seq_pkg::h_wait;
               end else if (oneshot_pend) begin
                  cmd_valid      <= 1'b1;
                  cmd_code       <= adc_seq_pkg::wakeup_cmd;
                  oneshot_active <= 1'b1;
                  state          <= adc_seq_pkg::h_wait;
               end else if (run_i) begin
                  state <= adc_seq_pkg::h_wait;
               end
            end
            adc_seq_pkg::h_wait: begin
               if (data_pending && fifo_in_ready && oneshot_active) begin
                  cmd_valid <= 1'b1;
                  cmd_code  <= adc_seq_pkg::read_data_cmd;
                  state     <= adc_seq_pkg::h_standby;
               end else if (data_pending && fifo_in_ready) begin
                  // the write restarts, nothing to discard
                  cmd_valid <= 1'b1;
                  cmd_code  <= adc_seq_pkg::register_write_cmd;
                  cmd_data  <= next_select_i;
                  state     <= adc_seq_pkg::h_read;
               end else if (!run_i && !oneshot_active) begin
                  state <= adc_seq_pkg::h_idle;
               end
            end
            adc_seq_pkg::h_read: begin
               cmd_valid <= 1'b1;
               cmd_code  <= adc_seq_pkg::read_data_cmd;
               state     <= adc_seq_pkg::h_wait;
            end
            adc_seq_pkg::h_standby: begin
               cmd_valid      <= 1'b1;
               cmd_code       <= adc_seq_pkg::standby_cmd;
               oneshot_active <= 1'b0;
               state          <= adc_seq_pkg::h_idle;
            end
         endcase
      end
   end

   assign link.cmd_valid             = cmd_valid;
   assign link.cmd_code              = cmd_code;
   assign link.cmd_data              = cmd_data;
   assign link.restart_powerdown_pin = restart_pin;
   assign busy_o                     = (state != adc_seq_pkg::h_idle);

   // result word is still when read: it changes only a period after ready falls
   result_fifo #(
      .WIDTH (`RESULT_WIDTH),
      .DEPTH (`FIFO_DEPTH)
   ) u_fifo (
      .clock_i     (clock_i),
      .rst_b_i     (rst_b_i),
      .in_valid_i  (push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (link.result_data),
      .out_valid_o (result_valid_o),
      .out_ready_i (result_ready_i),
      .out_data_o  (result_data_o)
   );

endmodule : adc_host_controller

// *** pkg/adc_link_if.sv ***
// Purpose: link between host controller and converter sequencer
// Assumes: host makes link_clk and changes its outputs on the falling edge
// Notes:   converter end samples everything on the rising edge of link_clk
`timescale 1ns/1ps
interface adc_link_if;
   logic                       link_clk;
   logic                       restart_powerdown_pin;
   logic                       cmd_valid;
   adc_seq_pkg::cmd_code_type  cmd_code;
   logic [7:0]                 cmd_data;
   logic                       result_ready_n;
   logic [23:0]                result_data;

   modport device (
      input  link_clk,
      input  restart_powerdown_pin,
      input  cmd_valid,
      input  cmd_code,
      input  cmd_data,
      output result_ready_n,
      output result_data
   );

   modport host (
      output link_clk,
      output restart_powerdown_pin,
      output cmd_valid,
      output cmd_code,
      output cmd_data,
      input  result_ready_n,
      input  result_data
   );
endinterface : adc_link_if

// *** pkg/adc_seq_defs.svh ***
// Purpose: constants shared by both ends of the converter sequencing link
// Assumes: included by bare name wherever a figure is needed
// Notes:   rates are in samples per second, settle figures in result periods
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH

// output data rates selected by the two-bit rate code
`define RATE_30K_SPS        30000
`define RATE_15K_SPS        15000
`define RATE_7500_SPS       7500
`define RATE_3750_SPS       3750
// settling figures, in result periods, for each rate code
`define SETTLE_30K_PERIODS  16'h0005
`define SETTLE_15K_PERIODS  16'h0003
`define SETTLE_7500_PERIODS 16'h0002
`define SETTLE_SLOW_PERIODS 16'h0001
// input selection fields: positive input high digit, negative low digit
`define SELECT_POS_MSB      7
`define SELECT_POS_LSB      4
`define SELECT_NEG_MSB      3
`define SELECT_NEG_LSB      0
`define SELECT_RESET        8'h01
// result coding, two's complement full-scale codes
`define RESULT_WIDTH        24
`define RESULT_POS_FULL     24'h7fffff
`define RESULT_NEG_FULL     24'h800000
// host clock divided by four makes the link clock
`define LINK_DIV_LAST       2'h3
`define LINK_CLOCK_HZ       5000000
`define FIFO_DEPTH          8

`endif

// *** pkg/adc_seq_pkg.sv ***
// Purpose: types shared by both ends of the converter sequencing link
// Assumes: constants live in adc_seq_defs.svh
// Notes:   command codes travel on the link as two bits
package adc_seq_pkg;

   // commands carried on the link while cmd_valid is high
   typedef enum logic [1:0] {
      register_write_cmd = 2'b00,
      read_data_cmd      = 2'b01,
      standby_cmd        = 2'b10,
      wakeup_cmd         = 2'b11
   } cmd_code_type;

   // converter end sequencing states
   typedef enum logic [1:0] {
      dev_restart    = 2'b00,
      dev_settling   = 2'b01,
      dev_converting = 2'b10,
      dev_standby    = 2'b11
   } dev_state_type;

   // host end sequencing states
   typedef enum logic [1:0] {
      h_idle    = 2'b00,
      h_wait    = 2'b01,
      h_read    = 2'b10,
      h_standby = 2'b11
   } host_state_type;

endpackage : adc_seq_pkg

// *** test/adc_link_properties.sv ***
// Purpose: timing checks on the converter link, watched on its wires
// Assumes: link_clk is made by the host; rst_b_i is the converter end's reset
// Notes:   settle window spans all four rates, loose by a few edges at its ends; the period check is exact
`timescale 1ns/1ps
module adc_link_properties #(
   parameter int LINK_CLOCK_HZ = 5000000
) (
   input wire logic                      link_clk,
   input wire logic                      rst_b_i,
   input wire logic                      restart_powerdown_pin,
   input wire logic                      cmd_valid,
   input wire adc_seq_pkg::cmd_code_type cmd_code,
   input wire logic                      result_ready_n,
   input wire logic [23:0]               result_data
);
   localparam int P0 = LINK_CLOCK_HZ / 30000;
   localparam int P1 = LINK_CLOCK_HZ / 15000;
   localparam int P2 = LINK_CLOCK_HZ / 7500;
   localparam int P3 = LINK_CLOCK_HZ / 3750;
   logic        take_wr;
   logic        take_wk;
   logic        take_sb;
   logic        evt;
   logic        fell;
   logic        ready_q;
   logic        standby;
   logic        pending;
   logic        had_fall;
   logic [15:0] since;
   logic [15:0] gap;

   default clocking cb @(posedge link_clk); endclocking
   default disable iff (!rst_b_i);

   // commands as the converter takes them; the pin overrides every command
   assign take_wr = cmd_valid && !restart_powerdown_pin
                    && (cmd_code == adc_seq_pkg::register_write_cmd);
   assign take_wk = cmd_valid && !restart_powerdown_pin
                    && (cmd_code == adc_seq_pkg::wakeup_cmd);
   assign take_sb = cmd_valid && !restart_powerdown_pin
                    && (cmd_code == adc_seq_pkg::standby_cmd);
   // a wake outside low power and a write inside it start nothing
   assign evt  = restart_powerdown_pin || (take_wr && !standby) || (take_wk && standby);
   assign fell = ready_q && !result_ready_n;

   // shadow of the low-power state
   always_ff @(posedge link_clk) begin
      if (!rst_b_i || restart_powerdown_pin || take_wk) standby <= 1'b0;
      else if (take_sb) standby <= 1'b1;
   end

   // edges since the last restart, change or wake
   always_ff @(posedge link_clk) begin
      if (!rst_b_i || evt) begin
         since   <= 16'h0000;
         pending <= 1'b1;
      end else begin
         if (since != 16'hffff) since <= since + 16'h0001;
         if (fell) pending <= 1'b0;
      end
   end

   // edges between ready falls, valid only inside one continuous run
   always_ff @(posedge link_clk) begin
      ready_q <= rst_b_i ? result_ready_n : 1'b1;
      if (!rst_b_i || evt) had_fall <= 1'b0;
      else if (fell) had_fall <= 1'b1;
      if (fell) gap <= 16'h0001;
      else if (gap != 16'hffff) gap <= gap + 16'h0001;
   end

   property p_write_ready_high;
      take_wr && !standby |=> result_ready_n [*8];
   endproperty
   a_write_ready_high: assert property (p_write_ready_high) else $error("ready fell after write");
   property p_first_settled;
      $fell(result_ready_n) && pending |-> since >= 16'd829 && since <= 16'd1340;
   endproperty
   a_first_settled: assert property (p_first_settled) else $error("first result not settled");
   property p_pin_ready_high;
      restart_powerdown_pin |=> result_ready_n;
   endproperty
   a_pin_ready_high: assert property (p_pin_ready_high) else $error("ready low under pin");
   property p_release_holds;
      $fell(restart_powerdown_pin) |-> result_ready_n [*8];
   endproperty
   a_release_holds: assert property (p_release_holds) else $error("ready low after restart");
   property p_data_at_fall;
      !$fell(result_ready_n) |-> $stable(result_data);
   endproperty
   a_data_at_fall: assert property (p_data_at_fall) else $error("result moved without ready");
   property p_period;
      $fell(result_ready_n) && !pending && had_fall |-> gap == P0 || gap == P1
                                                      || gap == P2 || gap == P3;
   endproperty
   a_period: assert property (p_period) else $error("ready period wrong");
   property p_raise_then_fall;
      $rose(result_ready_n) && !$past(cmd_valid) && !$past(restart_powerdown_pin)
         |=> !result_ready_n;
   endproperty
   a_raise_then_fall: assert property (p_raise_then_fall) else $error("continuous result lost");
   property p_pin_one_period;
      $rose(restart_powerdown_pin) |=> !restart_powerdown_pin;
   endproperty
   a_pin_one_period: assert property (p_pin_one_period) else $error("restart pulse too long");

   c_restart: cover property ($fell(restart_powerdown_pin));
   c_write: cover property (take_wr);
   c_wake: cover property (take_wk && standby);
endmodule : adc_link_properties

// *** test/tb.sv ***
// Purpose: drives both link ends, checks timing, coding and the result fifo
// Assumes: host makes the link clock; converter reset is held 43 cycles
// Notes:   results are noted in a queue and compared when popped
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin fail_count++; \
   $display("[ERR] %0t got %h want %h", $time, got, exp); end end
module tb;
   logic               clock_i = 1'b0;
   logic               rst_b = 1'b0;
   logic               dev_rst_b = 1'b0;
   logic               run = 1'b0;
   logic               oneshot = 1'b0;
   logic               restart = 1'b0;
   logic               res_rdy = 1'b1;
   logic [7:0]         nsel = 8'h01;
   logic [1:0]         rate = 2'h0;
   logic signed [31:0] sample = 32'sh00123456;
   logic               res_valid, busy, stby;
   logic [23:0]        res_data, run_exp, want, rnd;
   logic [3:0]         pos, neg;
   logic [23:0]        expq[$];
   int                 fail_count = 0, compares = 0, cycles = 0;
   int                 sps[4] = '{30000, 15000, 7500, 3750};
   int                 per[4] = '{5, 3, 2, 1};
   logic signed [31:0] vals[7] = '{32'sh007fffff, -32'sd8388608, 32'sh7fffffff,
                                   32'sh80000000, 32'sh00800000, -32'sd8388609, -32'sd1};

   always #25 clock_i = ~clock_i;
   adc_link_if link();
   adc_host_controller i_adc_host_controller (.link(link), .clock_i(clock_i),
      .rst_b_i(rst_b), .run_i(run), .next_select_i(nsel), .oneshot_i(oneshot),
      .restart_i(restart), .result_valid_o(res_valid), .result_data_o(res_data),
      .result_ready_i(res_rdy), .busy_o(busy));
   adc_conversion_sequencer #(.LINK_CLOCK_HZ(5000000)) i_adc_conversion_sequencer (
      .link(link), .rst_b_i(dev_rst_b), .sample_value_i(sample), .rate_sel_i(rate),
      .positive_input_o(pos), .negative_input_o(neg), .standby_o(stby));
   adc_link_properties #(.LINK_CLOCK_HZ(5000000)) i_adc_link_properties (
      .link_clk(link.link_clk), .rst_b_i(dev_rst_b),
      .restart_powerdown_pin(link.restart_powerdown_pin), .cmd_valid(link.cmd_valid),
      .cmd_code(link.cmd_code), .result_ready_n(link.result_ready_n),
      .result_data(link.result_data));

   // clip to the two full-scale codes, never wrap
   function automatic logic [23:0] sat(input logic signed [31:0] v);
      if (v > 32'sh007fffff) return 24'h7fffff;
      if (v < -32'sd8388608) return 24'h800000;
      return v[23:0];
   endfunction : sat

   task give_verdict();
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // a hang counts as a mismatch and ends the run
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 95000) begin
         fail_count++;
         $display("[ERR] %0t timeout", $time);
         give_verdict();
      end
   end

   // popped results, sampled half a cycle away from the pop edge
   always @(negedge clock_i) begin
      if (res_valid === 1'b1 && res_rdy === 1'b1) begin
         want = (expq.size() > 0) ? expq.pop_front() : run_exp;
         `CHK(res_data, want)
      end
   end

   task tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick

   // wait on a link level, counting link edges; the bound cuts a stuck flag
   task link_until(input logic want_n, input logic on_pin, inout int k);
      for (int i = 0; i < 3000; i++) begin
         if ((on_pin ? link.restart_powerdown_pin : link.result_ready_n) === want_n) return;
         @(posedge link.link_clk);
         #1;
         k++;
      end
      `CHK(1'b0, 1'b1)
   endtask : link_until

   task wait_busy(input logic lvl, input int n);
      for (int i = 0; i < n && busy !== lvl; i++) tick(1);
      `CHK(busy, lvl)
   endtask : wait_busy

   // restart at a rate, then time the first fall and the next period
   task restart_rate(input int r);
      int k;
      int p;
      p = 5000000 / sps[r];
      k = 0;
      restart = 1'b1;
      tick(1);
      restart = 1'b0;
      link_until(1'b1, 1'b1, k);
      rate = r[1:0];
      link_until(1'b0, 1'b1, k);
      k = 0;
      link_until(1'b0, 1'b0, k);
      // settle interval after restart
      `CHK(k >= per[r] * p - 1 && k <= per[r] * p + 2, 1'b1)
      k = 0;
      link_until(1'b1, 1'b0, k);
      link_until(1'b0, 1'b0, k);
      `CHK(k, p)
      $display("test rate %0d done", r);
   endtask : restart_rate

   initial begin
      void'($urandom(18));
      tick(3);
      rst_b = 1'b1;
      tick(40);
      `CHK(link.result_ready_n, 1'b1)
      `CHK(res_valid, 1'b0)
      dev_rst_b = 1'b1;
      run_exp = sat(sample);
      tick(20);
      $display("test reset done");
      for (int r = 3; r >= 0; r--) restart_rate(r);
      // channel cycling with a new selection byte
      nsel = 8'h23;
      run = 1'b1;
      for (int i = 0; i < 8000 && pos !== 4'h2; i++) tick(1);
      `CHK(pos, 4'h2)
      `CHK(neg, 4'h3)
      run = 1'b0;
      wait_busy(1'b0, 8000);
      tick(100);
      $display("test cycling done");
      // one-shots into a stalled fifo: eight fit, the ninth must wait
      res_rdy = 1'b0;
      sample = vals[0];
      tick(2000);
      for (int i = 0; i < 9; i++) begin
         rnd = 24'($urandom());
         sample = (i < 7) ? vals[i] : {{8{rnd[23]}}, rnd};
         expq.push_back(sat(sample));
         oneshot = 1'b1;
         tick(1);
         oneshot = 1'b0;
         wait_busy(1'b1, 20);
         if (i < 8) wait_busy(1'b0, 6000);
      end
      tick(5000);
      `CHK(busy, 1'b1)
      `CHK(res_valid, 1'b1)
      res_rdy = 1'b1;
      wait_busy(1'b0, 8000);
      tick(50);
      `CHK(res_valid, 1'b0)
      `CHK(expq.size(), 0)
      `CHK(stby, 1'b1)
      $display("test one-shot done");
      give_verdict();
   end
endmodule : tb
